// >>> dv/sfg_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfg_pin_model #(parameter int W = 8) (
    // pad side of the port
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    // level the board puts on a floating pin
    input wire logic [W-1:0] ext_level,
    output logic     [W-1:0] pin_in
);
    // a driven pin shows the driver, a floating one the board level
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : sfg_pin_model
`default_nettype wire

// >>> dv/sfg_ports_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sfg_ports_properties #(parameter logic [2:0] PS_EXT_CLK = 3'h7) (
    // bus side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pce,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // ownership and pads
    input wire logic [4:0]  converter_channel_select,
    input wire logic [2:0]  timer_a_prescaler_select,
    input wire logic [2:0]  timer_b_prescaler_select,
    input wire logic [7:0]  conv_pin_oe,
    input wire logic [5:0]  six_pin_oe,
    input wire logic [7:0]  tmr_pin_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a transfer is a setup cycle followed by a completing access
    sequence s_setup; psel && !penable && pce && !pready; endsequence
    sequence s_done; psel && penable && pready; endsequence
    a_answer_next: assert property (s_setup |=> s_done) else $error("no answer");
    a_ready_pulse: assert property (s_done ##0 pce |=> !pready) else $error("pready held");
    a_error_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_reset_float: assert property ($rose(presetn) |->
        conv_pin_oe == 8'h00 && six_pin_oe == 6'h00 && tmr_pin_oe == 8'h00)
        else $error("pin driven after reset");
    a_conv_owned: assert property (pce && converter_channel_select < 5'h08 |=>
        !conv_pin_oe[$past(converter_channel_select[2:0])]) else $error("owned pin driven");
    a_tmr_clk_float: assert property (pce && timer_a_prescaler_select == PS_EXT_CLK |=>
        !tmr_pin_oe[6]) else $error("timer clock pin driven");
    a_tmrb_clk_float: assert property (pce && timer_b_prescaler_select == PS_EXT_CLK |=>
        !tmr_pin_oe[4]) else $error("timer b clock pin driven");
    // oe lands one edge after the register, so two edges after the write
    a_dir_drives_oe: assert property (s_done ##0 pwrite &&
        paddr[7:2] == sfg_pkg::IDX_CONV_DIR && converter_channel_select[4:3] != 2'b00
        |=> ##1 conv_pin_oe == $past(pwdata[7:0], 2)) else $error("oe not direction");
endmodule : sfg_ports_properties
bind sfg_ports sfg_ports_properties #(.PS_EXT_CLK(PS_EXT_CLK)) u_props (.pclk, .presetn,
    .pce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .converter_channel_select, .timer_a_prescaler_select, .timer_b_prescaler_select,
    .conv_pin_oe, .six_pin_oe, .tmr_pin_oe);
`default_nettype wire

// >>> dv/sfg_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sfg_ports_tb;
    logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr, er, tg;
    logic [7:0] paddr, cx, tx, co, ce, ci, to, te, ti, rd;
    logic [31:0] pwdata, prdata;
    logic [4:0] sel;
    logic [2:0] psa, psb;
    logic [5:0] sx, so, se, si;
    int errors, check_count;
    sfg_ports dut (.pclk, .presetn, .pce, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .converter_channel_select(sel),
        .timer_a_prescaler_select(psa), .timer_b_prescaler_select(psb), .conv_pin_in(ci),
        .conv_pin_out(co), .conv_pin_oe(ce), .six_pin_in(si), .six_pin_out(so),
        .six_pin_oe(se), .tmr_pin_in(ti), .tmr_pin_out(to), .tmr_pin_oe(te));
    sfg_pin_model #(.W(8)) u_cm (.pin_out(co), .pin_oe(ce), .ext_level(cx), .pin_in(ci));
    sfg_pin_model #(.W(6)) u_sm (.pin_out(so), .pin_oe(se), .ext_level(sx), .pin_in(si));
    sfg_pin_model #(.W(8)) u_tm (.pin_out(to), .pin_oe(te), .ext_level(tx), .pin_in(ti));
    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic test_done();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // one transfer; waits for pready, takes data at that edge
    task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so the next call never re-raises psel in this step
        @(posedge pclk);
    endtask : bus
    task automatic rdc(input logic [5:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00);
        chk(rd, e);
    endtask : rdc
    // reset held ten cycles; latches are left alone by it
    task automatic rst();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : rst
    // cuts a hang short
    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        test_done();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pce = 1'b1;
        {sel, psa, psb, cx, sx, tx} = {5'h1F, 6'h00, 8'h3C, 6'h15, 8'hFF};
        @(posedge pclk);
        rst();
        rdc(sfg_pkg::IDX_CONV_DIR, 8'h00);
        rdc(sfg_pkg::IDX_SIX_DIR, 8'h00);
        rdc(sfg_pkg::IDX_TMR_DIR, 8'h00);
        bus(1'b1, sfg_pkg::IDX_CONV_DATA, 8'hA5);
        bus(1'b1, sfg_pkg::IDX_SIX_DATA, 8'hFF);
        bus(1'b1, sfg_pkg::IDX_TMR_DATA, 8'h5A);
        repeat (6) @(posedge pclk);
        rdc(sfg_pkg::IDX_CONV_DATA, 8'h3C);
        rdc(sfg_pkg::IDX_SIX_DATA, 8'h15);
        rdc(sfg_pkg::IDX_TMR_DATA, 8'hFF);
        rst();
        // latch first, then turn the drivers on
        bus(1'b1, sfg_pkg::IDX_CONV_DIR, 8'hFF);
        bus(1'b1, sfg_pkg::IDX_SIX_DIR, 8'h3F);
        bus(1'b1, sfg_pkg::IDX_TMR_DIR, 8'hFF);
        rdc(sfg_pkg::IDX_CONV_DATA, 8'hA5);
        rdc(sfg_pkg::IDX_SIX_DATA, 8'h3F);
        rdc(sfg_pkg::IDX_TMR_DATA, 8'h5A);
        chk(ce, 8'hFF);
        chk(co, 8'hA5);
        chk(to, 8'h5A);
        chk({2'b00, so}, 8'h3F);
        chk({2'b00, se}, 8'h3F);
        sel <= 5'h05;
        bus(1'b1, sfg_pkg::IDX_CONV_DIR, 8'hDF);
        rdc(sfg_pkg::IDX_CONV_DATA, 8'h85);
        bus(1'b1, sfg_pkg::IDX_CONV_DIR, 8'hFF);
        rdc(sfg_pkg::IDX_CONV_DATA, 8'hA5);
        chk(ce, 8'hDF);
        sel <= 5'h0E;
        bus(1'b1, sfg_pkg::IDX_TMR_DIR, 8'hBF);
        rdc(sfg_pkg::IDX_TMR_DATA, 8'h1A);
        {sel, psa, psb} <= {5'h1F, 3'h7, 3'h7};
        bus(1'b1, sfg_pkg::IDX_TMR_DIR, 8'hFF);
        rdc(sfg_pkg::IDX_TMR_DATA, 8'h5A);
        chk(te, 8'hAF);
        bus(1'b1, sfg_pkg::IDX_TMR_DIR, 8'hAF);
        rdc(sfg_pkg::IDX_TMR_DATA, 8'h0A);
        bus(1'b1, sfg_pkg::IDX_SIX_DIR, 8'hC0);
        rdc(sfg_pkg::IDX_SIX_DIR, 8'h80);
        chk({2'b00, se}, 8'h04);
        tg = so[2];
        @(posedge pclk);
        chk({7'h00, so[2]}, {7'h00, ~tg});
        // with the enable low the clock-out flop must hold still
        pce <= 1'b0;
        @(posedge pclk);
        tg = so[2];
        repeat (4) @(posedge pclk);
        chk({7'h00, so[2]}, {7'h00, tg});
        pce <= 1'b1;
        bus(1'b0, 6'h04, 8'h00);
        chk({7'h00, er}, 8'h01);
        test_done();
    end
endmodule : sfg_ports_tb
`default_nettype wire

// >>> logic/sfg_pkg.sv
package sfg_pkg;

    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_CONV_DATA   = 6'h01;
    localparam logic [5:0] IDX_SIX_DATA    = 6'h02;
    localparam logic [5:0] IDX_TMR_DATA    = 6'h03;
    localparam logic [5:0] IDX_CONV_DIR    = 6'h05;
    localparam logic [5:0] IDX_SIX_DIR     = 6'h06;
    localparam logic [5:0] IDX_TMR_DIR     = 6'h07;

    // field positions
    localparam int CLKOUT_EN_BIT  = 7;  // enable bit inside six-bit direction
    localparam int CLKOUT_PIN_BIT = 2;  // six-bit port pin carrying the clock
    localparam int SIX_WIDTH      = 6;  // implemented bits of the six-bit port
    localparam int TMR_A_CLK_BIT  = 6;  // timer a external clock pin
    localparam int TMR_B_CLK_BIT  = 4;  // timer b external clock pin

    // converter channel numbering per port
    localparam logic [4:0] CONV_PORT_CH_BASE = 5'h00;
    localparam logic [4:0] TMR_PORT_CH_BASE  = 5'h08;
    localparam int         TMR_PORT_CH_NUM   = 7;

    // reset values
    localparam logic [7:0] DIR_RESET    = 8'h00;
    localparam logic [7:0] PIN_RESET    = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // prescaler code that routes the external pin to a timer
    localparam logic [2:0] PS_EXT_CLK_DEFAULT = 3'h7;

    // bus slave states
    typedef enum logic [1:0] {
        SFG_IDLE   = 2'b01,
        SFG_ANSWER = 2'b10
    } sfg_state_type;

endpackage : sfg_pkg

// >>> logic/sfg_ports.sv
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sfg_ports #(
    parameter logic [2:0] PS_EXT_CLK = sfg_pkg::PS_EXT_CLK_DEFAULT
) (
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pce,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // ownership from converter and timers
    input  wire logic [4:0]  converter_channel_select,
    input  wire logic [2:0]  timer_a_prescaler_select,
    input  wire logic [2:0]  timer_b_prescaler_select,
    // converter-shared port pins
    input  wire logic [7:0]  conv_pin_in,
    output var  logic [7:0]  conv_pin_out,
    output var  logic [7:0]  conv_pin_oe,
    // six-bit port pins
    input  wire logic [5:0]  six_pin_in,
    output var  logic [5:0]  six_pin_out,
    output var  logic [5:0]  six_pin_oe,
    // timer-shared port pins
    input  wire logic [7:0]  tmr_pin_in,
    output var  logic [7:0]  tmr_pin_out,
    output var  logic [7:0]  tmr_pin_oe
);

    localparam int NPIN = 22;

    sfg_pkg::sfg_state_type state_reg;
    logic [7:0]      conv_data_reg;
    logic [5:0]      six_data_reg;
    logic [7:0]      tmr_data_reg;
    logic [7:0]      conv_dir_reg;
    logic [5:0]      six_dir_reg;
    logic            clock_output_enable_reg;
    logic [7:0]      tmr_dir_reg;
    logic            clk_tgl_reg;
    logic [NPIN-1:0] sync1_reg;
    logic [NPIN-1:0] sync2_reg;
    logic [NPIN-1:0] sync3_reg;
    logic [NPIN-1:0] pin_reg;
    logic [7:0]      conv_own;
    logic [7:0]      tmr_own;
    logic [7:0]      conv_rd;
    logic [5:0]      six_rd;
    logic [7:0]      tmr_rd;
    logic [5:0]      idx;
    logic            do_write;
    logic            setup;
    logic            mapped;
    logic [31:0]     rdata_next;

    assign idx      = paddr[7:2];
    assign setup    = psel && !penable && (state_reg == sfg_pkg::SFG_IDLE);
    assign do_write = psel && penable && pwrite && (state_reg == sfg_pkg::SFG_ANSWER);

    // pin synchroniser; a change is taken once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else if (pce) begin
            sync1_reg <= {tmr_pin_in, six_pin_in, conv_pin_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_reg[g] <= 1'b0;
                end else if (pce && (sync2_reg[g] == sync3_reg[g])) begin
                    pin_reg[g] <= sync3_reg[g];
                end
            end
        end
        // converter channel ownership, one comparator per pin, plus timer clock ownership on timer port pins 6 and 4; timer port pin 7 has none
        for (g = 0; g < 8; g++) begin : g_own
            assign conv_own[g] = (converter_channel_select
                                  == sfg_pkg::CONV_PORT_CH_BASE + 5'(g));
            if (g < sfg_pkg::TMR_PORT_CH_NUM) begin : g_ch
                assign tmr_own[g] = (converter_channel_select
                                     == sfg_pkg::TMR_PORT_CH_BASE + 5'(g))
                    || (g == sfg_pkg::TMR_A_CLK_BIT
                        && timer_a_prescaler_select == PS_EXT_CLK)
                    || (g == sfg_pkg::TMR_B_CLK_BIT
                        && timer_b_prescaler_select == PS_EXT_CLK);
            end else begin : g_nch
                assign tmr_own[g] = 1'b0;
            end
        end
    endgenerate

    // read values: latch when output, zero when owned input, else pin
    assign conv_rd = (conv_dir_reg & conv_data_reg)
                   | (~conv_dir_reg & ~conv_own & pin_reg[7:0]);
    assign six_rd  = (six_dir_reg & six_data_reg)
                   | (~six_dir_reg & pin_reg[13:8]);
    assign tmr_rd  = (tmr_dir_reg & tmr_data_reg)
                   | (~tmr_dir_reg & ~tmr_own & pin_reg[21:14]);

    // read mux; unused upper bits read zero
    always_comb begin
        rdata_next = sfg_pkg::RDATA_RESET;
        mapped     = 1'b1;
        case (idx)
            sfg_pkg::IDX_CONV_DATA: rdata_next[7:0] = conv_rd;
            sfg_pkg::IDX_SIX_DATA:  rdata_next[5:0] = six_rd;
            sfg_pkg::IDX_TMR_DATA:  rdata_next[7:0] = tmr_rd;
            sfg_pkg::IDX_CONV_DIR:  rdata_next[7:0] = conv_dir_reg;
            sfg_pkg::IDX_SIX_DIR: begin
                rdata_next[5:0] = six_dir_reg;
                rdata_next[sfg_pkg::CLKOUT_EN_BIT] = clock_output_enable_reg;
            end
            sfg_pkg::IDX_TMR_DIR:   rdata_next[7:0] = tmr_dir_reg;
            default:                mapped = 1'b0;
        endcase
    end

    // bus slave: no wait state, pready and read data come from flops loaded at the setup edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= sfg_pkg::SFG_IDLE;
            pready    <= 1'b0;
            prdata    <= sfg_pkg::RDATA_RESET;
            pslverr   <= 1'b0;
        end else if (pce) begin
            case (state_reg)
                sfg_pkg::SFG_IDLE: begin
                    if (setup) begin
                        state_reg <= sfg_pkg::SFG_ANSWER;
                        pready    <= 1'b1;
                        prdata    <= pwrite ? sfg_pkg::RDATA_RESET : rdata_next;
                        pslverr   <= !mapped;
                    end
                end
                sfg_pkg::SFG_ANSWER: begin
                    state_reg <= sfg_pkg::SFG_IDLE;
                    pready    <= 1'b0;
                    pslverr   <= 1'b0;
                end
                default: begin
                    state_reg <= sfg_pkg::SFG_IDLE;
                    pready    <= 1'b0;
                    pslverr   <= 1'b0;
                end
            endcase
        end
    end

    // data latches have no reset so a warm reset keeps output values
    always_ff @(posedge pclk) begin
        if (pce && do_write) begin
            if (idx == sfg_pkg::IDX_CONV_DATA) conv_data_reg <= pwdata[7:0];
            if (idx == sfg_pkg::IDX_SIX_DATA)  six_data_reg  <= pwdata[5:0];
            if (idx == sfg_pkg::IDX_TMR_DATA)  tmr_data_reg  <= pwdata[7:0];
        end
    end

    // direction registers, cleared so pins start as inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_dir_reg            <= sfg_pkg::DIR_RESET;
            six_dir_reg             <= sfg_pkg::DIR_RESET[5:0];
            clock_output_enable_reg <= 1'b0;
            tmr_dir_reg             <= sfg_pkg::DIR_RESET;
        end else if (pce && do_write) begin
            if (idx == sfg_pkg::IDX_CONV_DIR) conv_dir_reg <= pwdata[7:0];
            if (idx == sfg_pkg::IDX_SIX_DIR) begin
                six_dir_reg             <= pwdata[5:0];
                clock_output_enable_reg <= pwdata[sfg_pkg::CLKOUT_EN_BIT];
            end
            if (idx == sfg_pkg::IDX_TMR_DIR) tmr_dir_reg <= pwdata[7:0];
        end
    end

    // clock-out toggle; pin must come from a flop, so it runs at half rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_tgl_reg <= 1'b0;
        end else if (pce) begin
            clk_tgl_reg <= clock_output_enable_reg ? !clk_tgl_reg : 1'b0;
        end
    end

    // pin drivers; a latch loaded before enabling avoids a glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_pin_out <= sfg_pkg::PIN_RESET;
            conv_pin_oe  <= sfg_pkg::PIN_RESET;
            six_pin_out  <= sfg_pkg::PIN_RESET[5:0];
            six_pin_oe   <= sfg_pkg::PIN_RESET[5:0];
            tmr_pin_out  <= sfg_pkg::PIN_RESET;
            tmr_pin_oe   <= sfg_pkg::PIN_RESET;
        end else if (pce) begin
            conv_pin_out <= conv_data_reg;
            conv_pin_oe  <= conv_dir_reg & ~conv_own;
            six_pin_out  <= six_data_reg;
            six_pin_oe   <= six_dir_reg;
            if (clock_output_enable_reg) begin
                six_pin_out[sfg_pkg::CLKOUT_PIN_BIT] <= clk_tgl_reg;
                six_pin_oe[sfg_pkg::CLKOUT_PIN_BIT]  <= 1'b1;
            end
            tmr_pin_out  <= tmr_data_reg;
            tmr_pin_oe   <= tmr_dir_reg & ~tmr_own;
        end
    end

endmodule : sfg_ports
`default_nettype wire
